// >>> rtl/sdbo_dev.sv
// Device end: burst mode register copies, burst ordering, strobe shaping, write recovery
//
// The register offsets and the strobed register port were decided locally.
module sdbo_dev
  import sdbo_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // Link to the controller
  sdbo_link_if.device link,
  // Device status
  output logic precharge_start_out,
  output logic [MR_W-1:0] active_mode_out
);

  typedef enum logic [2:0] {ST_IDLE, ST_WRITE, ST_RECOV, ST_RPRE, ST_RDATA, ST_RPOST} sdbo_dev_state_t;

  sdbo_dev_state_t state, next_state;
  logic [MR_W-1:0] burst_mode [2];
  logic [MR_W-1:0] next_burst_mode [2];
  logic [MR_W-1:0] frequency_set_point_register, next_frequency_set_point_register;
  logic [BEAT_W-1:0] beat, next_beat;
  logic [COL_W-1:0] col_q, next_col_q;
  logic bl32_q, next_bl32_q;
  logic acr_q, next_acr_q;
  logic [5:0] recov_cnt, next_recov_cnt;
  logic rd_valid, next_rd_valid;
  logic [WORD_W-1:0] rd_data, next_rd_data;
  logic dqs_t, next_dqs_t;
  logic dqs_oe_n, next_dqs_oe_n;
  logic mr_valid, next_mr_valid;
  logic [MR_W-1:0] mr_data, next_mr_data;
  logic next_precharge;
  logic [MR_W-1:0] next_active_mode;
  logic [WORD_W-1:0] mem [MEM_WORDS];
  logic mem_we;
  logic [5:0] mem_waddr;
  logic [5:0] mem_raddr;
  logic [MR_W-1:0] act;
  logic [BEAT_W-1:0] beat_last;
  logic [BEAT_W-1:0] post_last;
  logic half_sel;
  logic [3:0] low_idx;

  // Operating copy and burst-derived limits
  assign act = burst_mode[frequency_set_point_register[OP_SET_POINT_BIT]];
  assign beat_last = bl32_q ? BEAT_LAST_32 : BEAT_LAST_16;
  assign post_last = act[RD_POST_LEN_BIT] ? POST_LAST_LONG : POST_LAST_SHORT;

  // Read order: start at C3:C2 times four, wrap in sixteen, swap half after beat 15
  assign half_sel = col_q[2] ^ (bl32_q & beat[4]);
  assign low_idx = 4'({col_q[1:0], 2'h0} + beat[3:0]);
  assign mem_raddr = {col_q[3], half_sel, low_idx};

  // Link outputs
  assign link.dev_busy = (state != ST_IDLE);
  assign link.rd_valid = rd_valid;
  assign link.rd_data = rd_data;
  assign link.dqs_t = dqs_t;
  assign link.dqs_oe_n = dqs_oe_n;
  assign link.mr_valid = mr_valid;
  assign link.mr_data = mr_data;

  // Next-state and output computation
  always_comb
  begin
    next_state = state;
    next_burst_mode = burst_mode;
    next_frequency_set_point_register = frequency_set_point_register;
    next_beat = beat;
    next_col_q = col_q;
    next_bl32_q = bl32_q;
    next_acr_q = acr_q;
    next_recov_cnt = recov_cnt;
    next_rd_valid = 1'b0;
    next_rd_data = rd_data;
    next_dqs_t = 1'b0;
    next_dqs_oe_n = 1'b1;
    next_mr_valid = 1'b0;
    next_mr_data = mr_data;
    next_precharge = 1'b0;
    mem_we = 1'b0;
    mem_waddr = 6'h00;
    unique case (state)
      ST_IDLE:
      begin
        if (link.cmd_valid)
        begin
          case (link.cmd_op)
            SDBO_MRW:
            begin
              if (link.cmd_ma == MA_BURST_MODE)
              begin
                next_burst_mode[frequency_set_point_register[WR_SET_POINT_BIT]] = link.cmd_md;
              end
              if (link.cmd_ma == MA_SET_POINT)
              begin
                next_frequency_set_point_register = link.cmd_md;
              end
            end
            SDBO_MRR:
            begin
              next_mr_valid = 1'b1;
              if (link.cmd_ma == MA_BURST_MODE)
              begin
                next_mr_data = burst_mode[frequency_set_point_register[WR_SET_POINT_BIT]];
              end
              else if (link.cmd_ma == MA_SET_POINT)
              begin
                next_mr_data = frequency_set_point_register;
              end
              else
              begin
                next_mr_data = 8'h00;
              end
            end
            SDBO_WRITE, SDBO_READ:
            begin
              next_col_q = link.cmd_col;
              next_bl32_q = sdbo_is_bl32(act[BL_LSB +: 2], link.cmd_bl32);
              next_acr_q = link.cmd_auto_close_row;
              next_beat = 5'h00;
              next_state = (link.cmd_op == SDBO_WRITE) ? ST_WRITE : ST_RPRE;
            end
            default:
            begin
            end
          endcase
        end
      end
      ST_WRITE:
      begin
        if (link.wr_valid)
        begin
          mem_we = 1'b1;
          // Linear fill, C3:C2 ignored, C4 kept only for 16 beats
          mem_waddr = {col_q[3], bl32_q ? beat : {col_q[2], beat[3:0]}};
          next_beat = 5'(beat + 5'h01);
          if (beat == beat_last)
          begin
            next_recov_cnt = 6'(sdbo_recov_cycles(act[WR_RECOV_LSB +: 3]) - 6'h01);
            next_state = acr_q ? ST_RECOV : ST_IDLE;
          end
        end
      end
      ST_RECOV:
      begin
        // Internal precharge starts after the programmed count
        if (recov_cnt == 6'h00)
        begin
          next_precharge = 1'b1;
          next_state = ST_IDLE;
        end
        else
        begin
          next_recov_cnt = 6'(recov_cnt - 6'h01);
        end
      end
      ST_RPRE:
      begin
        next_dqs_oe_n = 1'b0;
        next_dqs_t = act[RD_PRE_TYPE_BIT] & beat[0];
        next_beat = 5'(beat + 5'h01);
        if (beat == PRE_LAST)
        begin
          next_beat = 5'h00;
          next_state = ST_RDATA;
        end
      end
      ST_RDATA:
      begin
        next_dqs_oe_n = 1'b0;
        next_dqs_t = beat[0];
        next_rd_valid = 1'b1;
        next_rd_data = mem[mem_raddr];
        next_beat = 5'(beat + 5'h01);
        if (beat == beat_last)
        begin
          next_beat = 5'h00;
          next_state = ST_RPOST;
        end
      end
      ST_RPOST:
      begin
        // Long form adds a high cycle between two low ones
        next_dqs_oe_n = 1'b0;
        next_dqs_t = (beat == 5'h01);
        next_beat = 5'(beat + 5'h01);
        if (beat == post_last)
        begin
          next_beat = 5'h00;
          next_state = ST_IDLE;
        end
      end
    endcase
    next_active_mode = next_burst_mode[next_frequency_set_point_register[OP_SET_POINT_BIT]];
  end

  // State registers
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      state <= ST_IDLE;
      burst_mode[0] <= BURST_MODE_RST;
      burst_mode[1] <= BURST_MODE_RST;
      frequency_set_point_register <= SET_POINT_RST;
      beat <= 5'h00;
      col_q <= 8'h00;
      bl32_q <= 1'b0;
      acr_q <= 1'b0;
      recov_cnt <= 6'h00;
      rd_valid <= 1'b0;
      rd_data <= 16'h0000;
      dqs_t <= 1'b0;
      dqs_oe_n <= 1'b1;
      mr_valid <= 1'b0;
      mr_data <= 8'h00;
      precharge_start_out <= 1'b0;
      active_mode_out <= BURST_MODE_RST;
    end
    else
    begin
      state <= next_state;
      burst_mode <= next_burst_mode;
      frequency_set_point_register <= next_frequency_set_point_register;
      beat <= next_beat;
      col_q <= next_col_q;
      bl32_q <= next_bl32_q;
      acr_q <= next_acr_q;
      recov_cnt <= next_recov_cnt;
      rd_valid <= next_rd_valid;
      rd_data <= next_rd_data;
      dqs_t <= next_dqs_t;
      dqs_oe_n <= next_dqs_oe_n;
      mr_valid <= next_mr_valid;
      mr_data <= next_mr_data;
      precharge_start_out <= next_precharge;
      active_mode_out <= next_active_mode;
    end
  end

  // Word storage, no reset
  always_ff @(posedge ref_clk_in)
  begin
    if (mem_we)
    begin
      mem[mem_waddr] <= link.wr_data;
    end
  end

endmodule // sdbo_dev

// >>> shared/sdbo_pkg.sv
// Shared constants, types and decode functions for the burst-order mode-set link
package sdbo_pkg;

  // Widths of link fields
  localparam int unsigned COL_W = 8;      // Column bits C9..C2, C1:C0 never sent
  localparam int unsigned WORD_W = 16;
  localparam int unsigned MA_W = 6;
  localparam int unsigned MR_W = 8;
  localparam int unsigned BEAT_W = 5;
  localparam int unsigned MEM_WORDS = 64;

  // Mode register addresses
  localparam logic [MA_W-1:0] MA_BURST_MODE = 6'h01;
  localparam logic [MA_W-1:0] MA_SET_POINT = 6'h0d;

  // Reset values
  localparam logic [MR_W-1:0] BURST_MODE_RST = 8'h00;
  localparam logic [MR_W-1:0] SET_POINT_RST = 8'h00;

  // Burst mode field positions
  localparam int unsigned BL_LSB = 0;
  localparam int unsigned RD_PRE_TYPE_BIT = 3;
  localparam int unsigned WR_RECOV_LSB = 4;
  localparam int unsigned RD_POST_LEN_BIT = 7;

  // Set point register field positions
  localparam int unsigned WR_SET_POINT_BIT = 6;
  localparam int unsigned OP_SET_POINT_BIT = 7;

  // Burst length codes
  localparam logic [1:0] BL_CODE_16 = 2'h0;
  localparam logic [1:0] BL_CODE_32 = 2'h1;
  localparam logic [1:0] BL_CODE_OTF = 2'h2;

  // Strobe timing in clock cycles
  localparam logic [BEAT_W-1:0] PRE_LAST = 5'h01;    // Two preamble cycles
  localparam logic [BEAT_W-1:0] POST_LAST_SHORT = 5'h00;
  localparam logic [BEAT_W-1:0] POST_LAST_LONG = 5'h02;
  localparam logic [BEAT_W-1:0] BEAT_LAST_16 = 5'h0f;
  localparam logic [BEAT_W-1:0] BEAT_LAST_32 = 5'h1f;

  // Controller register indices
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_WSEED = 8'h01;
  localparam logic [7:0] REG_STATUS = 8'h02;
  localparam logic [7:0] REG_RBUF = 8'h20;

  // Command register fields
  localparam int unsigned CMD_OP_LSB = 0;
  localparam int unsigned CMD_ACR_BIT = 3;
  localparam int unsigned CMD_BL32_BIT = 4;
  localparam int unsigned CMD_COL_LSB = 8;
  localparam int unsigned CMD_MA_LSB = 16;
  localparam int unsigned CMD_MD_LSB = 24;

  // Link commands
  typedef enum logic [2:0] {SDBO_NOP, SDBO_MRW, SDBO_MRR, SDBO_READ, SDBO_WRITE} sdbo_op_t;

  // Write recovery code to clock cycles
  function automatic logic [5:0] sdbo_recov_cycles(input logic [2:0] code);
    logic [5:0] cyc;
    cyc = 6'h06;
    case (code)
      3'h0: cyc = 6'h06;
      3'h1: cyc = 6'h0a;
      3'h2: cyc = 6'h10;
      3'h3: cyc = 6'h14;
      3'h4: cyc = 6'h18;
      3'h5: cyc = 6'h1e;
      3'h6: cyc = 6'h22;
      default: cyc = 6'h28;
    endcase
    return cyc;
  endfunction

  // Burst length code and command bit to a 32-beat flag
  function automatic logic sdbo_is_bl32(input logic [1:0] code, input logic otf_bit);
    logic res;
    res = 1'b0;
    case (code)
      BL_CODE_16: res = 1'b0;
      BL_CODE_32: res = 1'b1;
      BL_CODE_OTF: res = otf_bit;
      default: res = 1'b0;
    endcase
    return res;
  endfunction

endpackage

// >>> shared/sdbo_link_if.sv
// Link between the memory controller end and the device end
interface sdbo_link_if;
  import sdbo_pkg::*;

  logic cmd_valid;
  sdbo_op_t cmd_op;
  logic [COL_W-1:0] cmd_col;
  logic cmd_bl32;
  logic cmd_auto_close_row;
  logic [MA_W-1:0] cmd_ma;
  logic [MR_W-1:0] cmd_md;
  logic wr_valid;
  logic [WORD_W-1:0] wr_data;
  logic dev_busy;
  logic rd_valid;
  logic [WORD_W-1:0] rd_data;
  logic dqs_t;
  logic dqs_oe_n;
  logic mr_valid;
  logic [MR_W-1:0] mr_data;

  modport device (
    input cmd_valid, cmd_op, cmd_col, cmd_bl32, cmd_auto_close_row, cmd_ma, cmd_md, wr_valid, wr_data,
    output dev_busy, rd_valid, rd_data, dqs_t, dqs_oe_n, mr_valid, mr_data
  );

  modport ctrl (
    output cmd_valid, cmd_op, cmd_col, cmd_bl32, cmd_auto_close_row, cmd_ma, cmd_md, wr_valid, wr_data,
    input dev_busy, rd_valid, rd_data, dqs_t, dqs_oe_n, mr_valid, mr_data
  );
endinterface

// >>> rtl/sdbo_ctrl.sv
// Controller end: command register, write beat source, read capture buffer
module sdbo_ctrl
  import sdbo_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // Register port
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // Link to the device
  sdbo_link_if.ctrl link
);

  typedef enum logic [1:0] {C_IDLE, C_CMD, C_WDATA, C_DRAIN} sdbo_ctrl_state_t;

  sdbo_ctrl_state_t state, next_state;
  logic pending, next_pending;
  logic [31:0] cmd_reg, next_cmd_reg;
  logic [WORD_W-1:0] seed, next_seed;
  logic [BEAT_W-1:0] beat, next_beat;
  logic [5:0] rcount, next_rcount;
  logic [MR_W-1:0] mr_last, next_mr_last;
  logic [31:0] next_rdata;
  logic cmd_valid, next_cmd_valid;
  logic wr_valid, next_wr_valid;
  logic [WORD_W-1:0] wr_data, next_wr_data;
  logic [WORD_W-1:0] rbuf [32];
  logic is_write;
  logic bl32_cmd;
  logic [COL_W-1:0] col_out;

  // Command fields; writes get aligned columns
  assign is_write = (sdbo_op_t'(cmd_reg[CMD_OP_LSB +: 3]) == SDBO_WRITE);
  assign bl32_cmd = cmd_reg[CMD_BL32_BIT];
  assign col_out = is_write ? {cmd_reg[CMD_COL_LSB + 3 +: 5], 1'b0, 2'h0} & {5'h1f, ~bl32_cmd, 2'h0}
                            | {3'h0, cmd_reg[CMD_COL_LSB + 2] & ~bl32_cmd, 4'h0} >> 2
                            : cmd_reg[CMD_COL_LSB +: COL_W];

  // Link outputs
  assign link.cmd_valid = cmd_valid;
  assign link.cmd_op = sdbo_op_t'(cmd_reg[CMD_OP_LSB +: 3]);
  assign link.cmd_col = col_out;
  assign link.cmd_bl32 = bl32_cmd;
  assign link.cmd_auto_close_row = cmd_reg[CMD_ACR_BIT];
  assign link.cmd_ma = cmd_reg[CMD_MA_LSB +: MA_W];
  assign link.cmd_md = cmd_reg[CMD_MD_LSB +: MR_W];
  assign link.wr_valid = wr_valid;
  assign link.wr_data = wr_data;

  // Sequencing and register access
  always_comb
  begin
    next_state = state;
    next_pending = pending;
    next_cmd_reg = cmd_reg;
    next_seed = seed;
    next_beat = beat;
    next_rcount = rcount;
    next_mr_last = mr_last;
    next_cmd_valid = 1'b0;
    next_wr_valid = 1'b0;
    next_wr_data = wr_data;
    next_rdata = 32'h00000000;
    if (wr_in && addr_in == REG_CMD && !pending && state == C_IDLE)
    begin
      next_cmd_reg = wdata_in;
      next_pending = 1'b1;
    end
    if (wr_in && addr_in == REG_WSEED)
    begin
      next_seed = wdata_in[WORD_W-1:0];
    end
    if (rd_in)
    begin
      if (addr_in == REG_CMD)
      begin
        next_rdata = cmd_reg;
      end
      else if (addr_in == REG_WSEED)
      begin
        next_rdata = {16'h0000, seed};
      end
      else if (addr_in == REG_STATUS)
      begin
        next_rdata = {10'h000, rcount, mr_last, 7'h00, pending | (state != C_IDLE)};
      end
      else if (addr_in[7:5] == REG_RBUF[7:5])
      begin
        next_rdata = {16'h0000, rbuf[addr_in[4:0]]};
      end
    end
    if (link.mr_valid)
    begin
      next_mr_last = link.mr_data;
    end
    if (link.rd_valid)
    begin
      next_rcount = 6'(rcount + 6'h01);
    end
    unique case (state)
      C_IDLE:
      begin
        if (pending && !link.dev_busy)
        begin
          next_cmd_valid = 1'b1;
          next_pending = 1'b0;
          next_rcount = 6'h00;
          next_state = C_CMD;
        end
      end
      C_CMD:
      begin
        next_state = C_DRAIN;
        if (is_write)
        begin
          next_wr_valid = 1'b1;
          next_wr_data = seed;
          next_beat = 5'h00;
          next_state = C_WDATA;
        end
      end
      C_WDATA:
      begin
        if (beat == (bl32_cmd ? BEAT_LAST_32 : BEAT_LAST_16))
        begin
          next_state = C_DRAIN;
        end
        else
        begin
          next_wr_valid = 1'b1;
          next_wr_data = 16'(wr_data + 16'h0001);
          next_beat = 5'(beat + 5'h01);
        end
      end
      C_DRAIN:
      begin
        if (!link.dev_busy)
        begin
          next_state = C_IDLE;
        end
      end
    endcase
  end

  // State registers
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      state <= C_IDLE;
      pending <= 1'b0;
      cmd_reg <= 32'h00000000;
      seed <= 16'h0000;
      beat <= 5'h00;
      rcount <= 6'h00;
      mr_last <= 8'h00;
      rdata_out <= 32'h00000000;
      cmd_valid <= 1'b0;
      wr_valid <= 1'b0;
      wr_data <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      pending <= next_pending;
      cmd_reg <= next_cmd_reg;
      seed <= next_seed;
      beat <= next_beat;
      rcount <= next_rcount;
      mr_last <= next_mr_last;
      rdata_out <= next_rdata;
      cmd_valid <= next_cmd_valid;
      wr_valid <= next_wr_valid;
      wr_data <= next_wr_data;
    end
  end

  // Read capture in arrival order
  always_ff @(posedge ref_clk_in)
  begin
    if (link.rd_valid && rcount < 6'h20)
    begin
      rbuf[rcount[4:0]] <= link.rd_data;
    end
  end

endmodule // sdbo_ctrl

// >>> sim/sdbo_checker.sv
// Concurrent checks on the link between the controller and device ends
module sdbo_checker
  import sdbo_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // Link signals
  input wire logic cmd_valid,
  input wire sdbo_op_t cmd_op,
  input wire logic [COL_W-1:0] cmd_col,
  input wire logic cmd_bl32,
  input wire logic wr_valid,
  input wire logic dev_busy,
  input wire logic rd_valid,
  input wire logic dqs_t,
  input wire logic dqs_oe_n,
  input wire logic mr_valid,
  // Device status
  input wire logic precharge_start_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] beat_cnt;
  logic [5:0] next_beat_cnt;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (reset_in);

  // Beats seen so far in the current read burst
  always_comb
  begin
    next_beat_cnt = rd_valid ? beat_cnt + 6'h01 : 6'h00;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
      beat_cnt <= 6'h00;
    else
      beat_cnt <= next_beat_cnt;
  end

  // Strobe shapes around a read burst
  sequence pre_two;
    !dqs_t && !dqs_oe_n && !rd_valid ##1 !dqs_oe_n && !rd_valid ##1 rd_valid;
  endsequence
  sequence post_short;
    dqs_oe_n;
  endsequence
  sequence post_long;
    !dqs_oe_n && dqs_t ##1 !dqs_oe_n && !dqs_t ##1 dqs_oe_n;
  endsequence

  AST_WRITE_COL_ZERO: assert property ((cmd_valid && cmd_op == SDBO_WRITE) |-> cmd_col[1:0] == 2'h0)
    else $error("write command with nonzero C3 C2");
  AST_WRITE_BL32_ALIGN: assert property ((cmd_valid && cmd_op == SDBO_WRITE && cmd_bl32) |-> !cmd_col[2])
    else $error("32 beat write not aligned");
  AST_PRECHARGE_PULSE: assert property (precharge_start_out |=> !precharge_start_out)
    else $error("precharge start longer than one cycle");
  AST_RECOVERY_MIN: assert property (($fell(wr_valid) && !$past(reset_in)) |-> !precharge_start_out [*6])
    else $error("precharge before shortest recovery");
  AST_PREAMBLE: assert property ($fell(dqs_oe_n) |-> pre_two)
    else $error("read preamble not two cycles");
  AST_BEAT_STROBE: assert property (rd_valid |-> !dqs_oe_n && dqs_t == beat_cnt[0])
    else $error("strobe wrong during read beat");
  AST_BURST_LEN: assert property (($fell(rd_valid) && !$past(reset_in)) |-> (beat_cnt == 6'h10 || beat_cnt == 6'h20))
    else $error("read burst neither 16 nor 32 beats");
  AST_POSTAMBLE: assert property (($fell(rd_valid) && !$past(reset_in)) |-> (!dqs_oe_n && !dqs_t) ##1 (post_short or post_long))
    else $error("read postamble malformed");
  AST_WRITE_BUSY: assert property (wr_valid |-> dev_busy)
    else $error("write beat while device idle");
  AST_MR_PULSE: assert property (mr_valid |=> !mr_valid)
    else $error("mode read data pulse too long");
endmodule // sdbo_checker

// >>> sim/test_sdbo_burst_order_mode_set.sv
// Bench joining controller and device ends through the link
module test_sdbo_burst_order_mode_set
  import sdbo_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] SEED = 16'h3a50;
  logic ref_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [31:0] rdata_out;
  logic precharge_start_out;
  logic [MR_W-1:0] active_mode_out;
  int failures = 0;
  int checks_done = 0;

  sdbo_link_if link();
  sdbo_dev u_sdbo_dev (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .link(link),
    .precharge_start_out(precharge_start_out), .active_mode_out(active_mode_out));
  sdbo_ctrl u_sdbo_ctrl (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .link(link));
  sdbo_checker u_sdbo_checker (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .cmd_valid(link.cmd_valid),
    .cmd_op(link.cmd_op), .cmd_col(link.cmd_col), .cmd_bl32(link.cmd_bl32), .wr_valid(link.wr_valid),
    .dev_busy(link.dev_busy), .rd_valid(link.rd_valid), .dqs_t(link.dqs_t), .dqs_oe_n(link.dqs_oe_n),
    .mr_valid(link.mr_valid), .precharge_start_out(precharge_start_out));

  // 20 MHz clock
  always #25 ref_clk_in = ~ref_clk_in;

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("BAD %s exp %h got %h", what, exp, got);
      failures++;
    end
  endtask

  task automatic wrap_up();
    if (failures == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Register port cycles
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    @(posedge ref_clk_in);
    d = rdata_out;
  endtask

  // Poll until controller and device are both idle
  task automatic wait_idle();
    int w;
    logic [31:0] s;
    w = 0;
    do
    begin
      reg_rd(REG_STATUS, s);
      w++;
    end while ((s[0] !== 1'b0 || link.dev_busy !== 1'b0) && w < 100);
    check("idle", 32'h0, w >= 100);
  endtask

  task automatic cmd(input sdbo_op_t op, input logic acr, input logic b32, input logic [7:0] col,
    input logic [5:0] ma, input logic [7:0] md);
    reg_wr(REG_CMD, {md, 2'h0, ma, col, 3'h0, b32, acr, op});
  endtask

  task automatic mrw(input logic [5:0] ma, input logic [7:0] md);
    cmd(SDBO_MRW, 1'b0, 1'b0, 8'h00, ma, md);
    wait_idle();
  endtask

  task automatic mrr(input logic [5:0] ma, output logic [7:0] v);
    logic [31:0] s;
    cmd(SDBO_MRR, 1'b0, 1'b0, 8'h00, ma, 8'h00);
    wait_idle();
    reg_rd(REG_STATUS, s);
    v = s[15:8];
  endtask

  // Auto-close write, then cycles from last beat to precharge start
  task automatic wr_recov(input logic [2:0] code, input int exp_n);
    int k;
    int n;
    mrw(MA_BURST_MODE, {1'b0, code, 4'h2});
    check("mode", {1'b0, code, 4'h2}, active_mode_out);
    cmd(SDBO_WRITE, 1'b1, 1'b0, 8'h00, 6'h00, 8'h00);
    k = 0;
    n = 0;
    while (k < 16 && n < 100)
    begin
      @(posedge ref_clk_in);
      n++;
      if (link.wr_valid === 1'b1)
        k++;
    end
    n = 0;
    do
    begin
      @(posedge ref_clk_in);
      n++;
    end while (precharge_start_out !== 1'b1 && n < 60);
    check("recovery", exp_n + 1, n);
    wait_idle();
  endtask

  // Read burst with strobe shape and word order judged beat by beat
  task automatic rd_burst(input logic b32, input logic [7:0] col, input logic tog, input logic lng, input int n);
    int w;
    logic [4:0] ix;
    cmd(SDBO_READ, 1'b0, b32, col, 6'h00, 8'h00);
    w = 0;
    do
    begin
      @(posedge ref_clk_in);
      w++;
    end while (link.dqs_oe_n !== 1'b0 && w < 40);
    check("pre0", 32'h0, link.dqs_t);
    @(posedge ref_clk_in);
    check("pre1", tog, link.dqs_t);
    for (int i = 0; i < n; i++)
    begin
      @(posedge ref_clk_in);
      ix = {col[2] ^ (n == 32 && i >= 16), 4'((col[1:0] * 4 + i) % 16)};
      check("beat", 32'h1, link.rd_valid);
      check("data", 16'(SEED + ix), link.rd_data);
      check("dqs", i % 2, link.dqs_t);
    end
    @(posedge ref_clk_in);
    check("post0", 32'h0, {link.rd_valid, link.dqs_oe_n, link.dqs_t});
    if (lng)
    begin
      @(posedge ref_clk_in);
      check("post1", 32'h1, link.dqs_t);
      @(posedge ref_clk_in);
      check("post2", 32'h0, link.dqs_t);
    end
    @(posedge ref_clk_in);
    check("oe_end", 32'h1, link.dqs_oe_n);
    wait_idle();
  endtask

  task automatic t_reset();
    logic [31:0] s;
    logic [7:0] v;
    reg_rd(REG_STATUS, s);
    check("status", 32'h0, s);
    check("active", BURST_MODE_RST, active_mode_out);
    mrr(MA_SET_POINT, v);
    check("setpt", SET_POINT_RST, v);
    reg_rd(8'h10, s);
    check("unmapped", 32'h0, s);
    reg_wr(REG_WSEED, {16'h0, SEED});
  endtask

  task automatic t_recovery();
    int rec[8] = '{6, 10, 16, 20, 24, 30, 34, 40};
    for (int c = 0; c < 8; c++)
      wr_recov(3'(c), rec[c]);
  endtask

  // Two copies, written and operating set points chosen apart
  task automatic t_set_points();
    logic [7:0] v;
    mrw(MA_BURST_MODE, 8'h0a);
    mrw(MA_SET_POINT, 8'h40);
    mrw(MA_BURST_MODE, 8'h81);
    check("act0", 8'h0a, active_mode_out);
    mrr(MA_BURST_MODE, v);
    check("copy1", 8'h81, v);
    mrw(MA_SET_POINT, 8'h80);
    check("act1", 8'h81, active_mode_out);
    mrr(MA_BURST_MODE, v);
    check("copy0", 8'h0a, v);
    mrr(MA_SET_POINT, v);
    check("setpt", 8'h80, v);
    // Other mode addresses: writes ignored, reads give zero
    mrw(6'h02, 8'hff);
    check("act_other", 8'h81, active_mode_out);
    mrr(6'h02, v);
    check("mr_other", 8'h00, v);
  endtask

  task automatic t_bursts();
    logic [31:0] s;
    cmd(SDBO_WRITE, 1'b0, 1'b1, 8'h07, 6'h00, 8'h00);
    wait_idle();
    rd_burst(1'b1, 8'h06, 1'b0, 1'b1, 32);
    reg_rd(REG_STATUS, s);
    check("beats", 32'h20, s[21:16]);
    reg_rd(8'h3f, s);
    check("rbuf", 16'(SEED + 16'h0007), s[15:0]);
    mrw(MA_SET_POINT, 8'h00);
    rd_burst(1'b0, 8'h01, 1'b1, 1'b0, 16);
    rd_burst(1'b1, 8'h03, 1'b1, 1'b0, 32);
    mrw(MA_BURST_MODE, 8'h00);
    rd_burst(1'b1, 8'h06, 1'b0, 1'b0, 16);
    // Reserved length code runs as 16 beats
    mrw(MA_BURST_MODE, 8'h03);
    rd_burst(1'b1, 8'h00, 1'b0, 1'b0, 16);
  endtask

  // Main sequence
  initial
  begin
    repeat (10) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    t_reset();
    t_recovery();
    t_set_points();
    t_bursts();
    wrap_up();
  end

  // Watchdog against a hang
  initial
  begin
    #2000000;
    failures++;
    wrap_up();
  end
endmodule // test_sdbo_burst_order_mode_set
